// ---- logic/smt_pkg.sv ----
// Overview of operation
// - Bit 15 with analog LDO overvoltage monitor enabled forces that fault flag low.
// - Bit 14 with analog LDO undervoltage monitor enabled forces that fault flag low.
// - Bit 13 with IO LDO overvoltage monitor enabled forces that fault flag low.
// - Bit 12 with IO LDO undervoltage monitor enabled forces that fault flag low.
// - Bit 11 with digital LDO overvoltage monitor enabled forces that fault flag low.
// - Bit 10 with digital LDO undervoltage monitor enabled forces that fault flag low.
// - Bit 9 with analog LDO oscillation monitor enabled forces that fault flag low.
// - Bit 8 with IO LDO oscillation monitor enabled forces that fault flag low.
// - Bit 7 with digital LDO oscillation monitor enabled forces that fault flag low.
// - Bit 2 with ground A disconnect monitor enabled forces that fault flag low.
// - Bit 1 with ground B disconnect monitor enabled forces that fault flag low.
// - Bit 0 with digital ground disconnect monitor enabled forces that fault flag low.
// - Self-test register sits at 44h and resets to 0000h.
// - Bits 6:3 are reserved, read-only, always read zero.
// - Monitor enables live in their own register, reset to disabled.
package smt_pkg;
  localparam int unsigned CLK_MHZ        = 40;
  localparam int unsigned ADDR_W         = 8;
  localparam logic [7:0]  MON_EN_OFS     = 8'h40;
  localparam logic [7:0]  SELFTEST_OFS   = 8'h44;
  localparam logic [7:0]  IRQ_STATUS_OFS = 8'h48;
  localparam logic [7:0]  IRQ_MASK_OFS   = 8'h4c;
  localparam logic [7:0]  FAULT_STATE_OFS = 8'h50;
  localparam logic [15:0] SELFTEST_RST   = 16'h0000;
  localparam logic [15:0] MON_EN_RST     = 16'h0000;
  localparam logic [15:0] VALID_MASK     = 16'hff87;
  localparam int unsigned RSVD_LSB       = 3;
  localparam int unsigned RSVD_MSB       = 6;
  localparam int unsigned GND_LAST_BIT   = 2;
  localparam int unsigned SUP_PROP_NS    = 1000;
  localparam int unsigned GND_OPEN_NS    = 2000;
  localparam int unsigned SUP_PROP_RAW   = (SUP_PROP_NS * CLK_MHZ) / 1000;
  localparam int unsigned GND_OPEN_RAW   = (GND_OPEN_NS * CLK_MHZ) / 1000;
  localparam int unsigned SUP_PROP_CYC   = (SUP_PROP_RAW < 1) ? 1 : SUP_PROP_RAW;
  localparam int unsigned GND_OPEN_CYC   = (GND_OPEN_RAW < 1) ? 1 : GND_OPEN_RAW;
  localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
  localparam logic        HRESP_OKAY     = 1'b0;

  typedef struct packed {
    logic       analog_ldo_overvolt;
    logic       analog_ldo_undervolt;
    logic       io_ldo_overvolt;
    logic       io_ldo_undervolt;
    logic       digital_ldo_overvolt;
    logic       digital_ldo_undervolt;
    logic       analog_ldo_oscillation;
    logic       io_ldo_oscillation;
    logic       digital_ldo_oscillation;
    logic [3:0] reserved;
    logic       analog_ground_a_disconnect;
    logic       analog_ground_b_disconnect;
    logic       digital_ground_disconnect;
  } smt_mon_type;

  typedef enum logic [2:0] {
    SMT_SEL_NONE,
    SMT_SEL_MON_EN,
    SMT_SEL_SELFTEST,
    SMT_SEL_STATUS,
    SMT_SEL_MASK,
    SMT_SEL_FAULT
  } smt_sel_type;
endpackage : smt_pkg

// ---- logic/smt_selftest_cfg.sv ----
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
module smt_selftest_cfg #(
  parameter int unsigned SUP_DELAY_CYC = smt_pkg::SUP_PROP_CYC,
  parameter int unsigned GND_DELAY_CYC = smt_pkg::GND_OPEN_CYC,
  parameter int unsigned CNT_W         = 8
) (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic               hready,
  input  wire logic [31:0]        hwdata,
  output logic      [31:0]        hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  input  wire smt_pkg::smt_mon_type monitor_trip,
  output smt_pkg::smt_mon_type    monitor_en,
  output smt_pkg::smt_mon_type    fault_n,
  output logic                    irq
);

  localparam int SUP_DLY = int'(SUP_DELAY_CYC);
  localparam int GND_DLY = int'(GND_DELAY_CYC);

  if (SUP_DELAY_CYC < 1 || SUP_DELAY_CYC >= (1 << CNT_W) ||
      GND_DELAY_CYC < 1 || GND_DELAY_CYC >= (1 << CNT_W)) begin : g_bad_delay
    $error("smt_selftest_cfg: delay counts do not fit the counter width");
  end

  function automatic smt_pkg::smt_sel_type reg_sel(input logic [smt_pkg::ADDR_W-1:0] ofs);
    smt_pkg::smt_sel_type sel;
    sel = smt_pkg::SMT_SEL_NONE;
    if (ofs == smt_pkg::MON_EN_OFS) sel = smt_pkg::SMT_SEL_MON_EN;
    if (ofs == smt_pkg::SELFTEST_OFS) sel = smt_pkg::SMT_SEL_SELFTEST;
    if (ofs == smt_pkg::IRQ_STATUS_OFS) sel = smt_pkg::SMT_SEL_STATUS;
    if (ofs == smt_pkg::IRQ_MASK_OFS) sel = smt_pkg::SMT_SEL_MASK;
    if (ofs == smt_pkg::FAULT_STATE_OFS) sel = smt_pkg::SMT_SEL_FAULT;
    return sel;
  endfunction : reg_sel

  // Bus state
  logic                         wr_pend_q;
  logic [smt_pkg::ADDR_W-1:0]   wr_ofs_q;
  logic [31:0]                  hrdata_q;
  logic                         hreadyout_q;

  // Register state
  logic [15:0] mon_en_q;
  logic [15:0] mon_en_d;
  logic [15:0] selftest_q;
  logic [15:0] selftest_d;
  logic [15:0] status_q;
  logic [15:0] status_d;
  logic [15:0] mask_q;
  logic [15:0] mask_d;
  logic [15:0] fault_n_q;
  logic [15:0] fault_d;
  logic [15:0] act_w;
  logic        irq_q;

  wire                         addr_ph  = hsel && hready && htrans == smt_pkg::HTRANS_NONSEQ;
  wire smt_pkg::smt_sel_type   rd_sel   = reg_sel(haddr[smt_pkg::ADDR_W-1:0]);
  wire smt_pkg::smt_sel_type   wr_sel   = reg_sel(wr_ofs_q);
  wire [15:0]                  wdata    = hwdata[15:0];
  wire [15:0]                  trip_v   = monitor_trip;
  wire                         wr_mon   = wr_pend_q && wr_sel == smt_pkg::SMT_SEL_MON_EN;
  wire                         wr_st    = wr_pend_q && wr_sel == smt_pkg::SMT_SEL_SELFTEST;
  wire                         wr_stat  = wr_pend_q && wr_sel == smt_pkg::SMT_SEL_STATUS;
  wire                         wr_mask  = wr_pend_q && wr_sel == smt_pkg::SMT_SEL_MASK;
  // Fault flag newly raised this cycle
  wire [15:0]                  fault_rise = fault_d & fault_n_q;

  // Reserved bits cannot be written
  assign mon_en_d   = wr_mon ? (wdata & smt_pkg::VALID_MASK) : mon_en_q;
  assign selftest_d = wr_st ? (wdata & smt_pkg::VALID_MASK) : selftest_q;
  assign mask_d     = wr_mask ? (wdata & smt_pkg::VALID_MASK) : mask_q;
  // Set beats clear so an event during a clear is kept
  assign status_d   = (status_q & ~(wr_stat ? wdata : 16'h0000)) | fault_rise;

  // Read mux looks at next values so a read right after a write sees it
  logic [15:0] rd_val;
  always_comb begin
    rd_val = 16'h0000;
    unique case (rd_sel)
      smt_pkg::SMT_SEL_MON_EN:   rd_val = mon_en_d;
      smt_pkg::SMT_SEL_SELFTEST: rd_val = selftest_d;
      smt_pkg::SMT_SEL_STATUS:   rd_val = status_d;
      smt_pkg::SMT_SEL_MASK:     rd_val = mask_d;
      smt_pkg::SMT_SEL_FAULT:    rd_val = fault_d;
      smt_pkg::SMT_SEL_NONE:     rd_val = 16'h0000;
    endcase
  end
  wire [31:0] rdata_d = (addr_ph && !hwrite) ? {16'h0000, rd_val} : 32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
    end else begin
      wr_pend_q <= addr_ph && hwrite;
    end
  end

  // Offset is captured every cycle; only wr_pend_q qualifies it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ofs_q <= '0;
    end else begin
      wr_ofs_q <= haddr[smt_pkg::ADDR_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else begin
      hrdata_q <= rdata_d;
    end
  end

  // Zero wait states; low while reset holds and until the first edge after release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_q <= 1'b0;
    end else begin
      hreadyout_q <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mon_en_q <= smt_pkg::MON_EN_RST;
    end else begin
      mon_en_q <= mon_en_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      selftest_q <= smt_pkg::SELFTEST_RST;
    end else begin
      selftest_q <= selftest_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_q <= 16'h0000;
    end else begin
      status_q <= status_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_q <= 16'h0000;
    end else begin
      mask_q <= mask_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault_n_q <= 16'hffff;
    end else begin
      fault_n_q <= ~fault_d;
    end
  end

  // Registered so the pin never glitches while status and mask change together
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_d & mask_d);
    end
  end

  // One self-test timer per monitor; ground monitors use the open-detection delay
  for (genvar i = 0; i < 16; i++) begin : g_mon
    if (smt_pkg::VALID_MASK[i]) begin : g_used
      localparam int unsigned DLY = (i <= smt_pkg::GND_LAST_BIT) ? GND_DELAY_CYC : SUP_DELAY_CYC;
      logic [CNT_W-1:0] cnt_q;
      logic [CNT_W-1:0] cnt_d;
      logic             hit;
      // Timer restarts whenever the test or its monitor drops
      assign act_w[i] = selftest_q[i] && mon_en_q[i];
      assign hit      = act_w[i] && cnt_q == CNT_W'(DLY - 1);
      assign cnt_d    = !act_w[i] ? '0 : (hit ? cnt_q : cnt_q + 1'b1);
      // A disabled monitor never flags, test or not
      assign fault_d[i] = mon_en_q[i] && (trip_v[i] || hit);
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cnt_q <= '0;
        end else begin
          cnt_q <= cnt_d;
        end
      end

      a_timer_bound:
        assert property (@(posedge hclk) disable iff (!hresetn) cnt_q <= CNT_W'(DLY - 1))
        else $error("self-test timer ran past its delay");
      a_status_on_fall:
        assert property (@(posedge hclk) disable iff (!hresetn) $fell(fault_n_q[i]) |-> status_q[i])
        else $error("status bit missed a new fault");
    end else begin : g_rsvd
      assign act_w[i]   = 1'b0;
      assign fault_d[i] = 1'b0;
    end
  end

  assign hrdata     = hrdata_q;
  assign hreadyout  = hreadyout_q;
  assign hresp      = smt_pkg::HRESP_OKAY;
  assign monitor_en = smt_pkg::smt_mon_type'(mon_en_q);
  assign fault_n    = smt_pkg::smt_mon_type'(fault_n_q);
  assign irq        = irq_q;

  // Checks
  property p_sup_test(int b);
    @(posedge hclk) disable iff (!hresetn)
      $rose(act_w[b]) ##0 (act_w[b] throughout ##SUP_DLY 1'b1) |-> !fault_n_q[b];
  endproperty
  property p_gnd_test(int b);
    @(posedge hclk) disable iff (!hresetn)
      $rose(act_w[b]) ##0 (act_w[b] throughout ##GND_DLY 1'b1) |-> !fault_n_q[b];
  endproperty

  a_aldo_ov_test:
    assert property (p_sup_test(15)) else $error("analog ldo overvolt self-test flag missing");
  a_aldo_uv_test:
    assert property (p_sup_test(14)) else $error("analog ldo undervolt self-test flag missing");
  a_ioldo_ov_test:
    assert property (p_sup_test(13)) else $error("io ldo overvolt self-test flag missing");
  a_ioldo_uv_test:
    assert property (p_sup_test(12)) else $error("io ldo undervolt self-test flag missing");
  a_dldo_ov_test:
    assert property (p_sup_test(11)) else $error("digital ldo overvolt self-test flag missing");
  a_dldo_uv_test:
    assert property (p_sup_test(10)) else $error("digital ldo undervolt self-test flag missing");
  a_aldo_osc_test:
    assert property (p_sup_test(9)) else $error("analog ldo oscillation self-test flag missing");
  a_ioldo_osc_test:
    assert property (p_sup_test(8)) else $error("io ldo oscillation self-test flag missing");
  a_dldo_osc_test:
    assert property (p_sup_test(7)) else $error("digital ldo oscillation self-test flag missing");
  a_gnda_disc_test:
    assert property (p_gnd_test(2)) else $error("ground a disconnect self-test flag missing");
  a_gndb_disc_test:
    assert property (p_gnd_test(1)) else $error("ground b disconnect self-test flag missing");
  a_dgnd_disc_test:
    assert property (p_gnd_test(0)) else $error("digital ground disconnect self-test flag missing");

  a_cfg_reset_value:
    assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(hresetn) |-> selftest_q == smt_pkg::SELFTEST_RST && mon_en_q == smt_pkg::MON_EN_RST)
    else $error("config registers not cleared by reset");
  a_cfg_write_take:
    assert property (@(posedge hclk) disable iff (!hresetn)
      wr_pend_q && wr_ofs_q == smt_pkg::SELFTEST_OFS |=>
        selftest_q == ($past(hwdata[15:0]) & smt_pkg::VALID_MASK))
    else $error("self-test register write not taken");
  a_rsvd_read_zero:
    assert property (@(posedge hclk) disable iff (!hresetn)
      addr_ph && !hwrite && haddr[smt_pkg::ADDR_W-1:0] == smt_pkg::SELFTEST_OFS |=>
        hrdata[smt_pkg::RSVD_MSB:smt_pkg::RSVD_LSB] == 4'h0 && hrdata[15:0] == selftest_q)
    else $error("self-test readback wrong or reserved bits set");
  a_mon_en_take:
    assert property (@(posedge hclk) disable iff (!hresetn)
      wr_pend_q && wr_ofs_q == smt_pkg::MON_EN_OFS |=>
        mon_en_q == ($past(hwdata[15:0]) & smt_pkg::VALID_MASK))
    else $error("monitor enable register write not taken");
  a_no_fault_off:
    assert property (@(posedge hclk) disable iff (!hresetn)
      ((~fault_n_q) & ~$past(mon_en_q)) == 16'h0000)
    else $error("fault flag raised by a disabled monitor");
  a_clear_release:
    assert property (@(posedge hclk) disable iff (!hresetn)
      ((~fault_n_q) & ~$past(selftest_q) & ~$past(trip_v)) == 16'h0000)
    else $error("fault flag held after self-test cleared");
  a_irq_follows:
    assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(irq) |-> $past(|(status_d & mask_d)) ##1 1'b1)
    else $error("interrupt raised without an unmasked status bit");
  a_irq_level:
    assert property (@(posedge hclk) disable iff (!hresetn)
      irq == |(status_q & mask_q))
    else $error("interrupt level disagrees with status and mask");

  // Register and bus behaviour
  a_rsvd_fixed:
    assert property (@(posedge hclk) disable iff (!hresetn)
      selftest_q[smt_pkg::RSVD_MSB:smt_pkg::RSVD_LSB] == 4'h0 &&
        fault_n_q[smt_pkg::RSVD_MSB:smt_pkg::RSVD_LSB] == 4'hf)
    else $error("reserved self-test or fault bits not at their fixed value");
  a_status_w1c:
    assert property (@(posedge hclk) disable iff (!hresetn)
      wr_stat |=> (status_q & $past(wdata) & ~$past(fault_rise)) == 16'h0000)
    else $error("status bits not cleared by a one");
  a_status_sticky:
    assert property (@(posedge hclk) disable iff (!hresetn)
      !wr_stat |=> ($past(status_q) & ~status_q) == 16'h0000)
    else $error("status bit lost without a clear");
  a_idle_rdata_zero:
    assert property (@(posedge hclk) disable iff (!hresetn)
      !(addr_ph && !hwrite) |=> hrdata == 32'h0000_0000)
    else $error("read data present outside a read data phase");
  a_mask_take:
    assert property (@(posedge hclk) disable iff (!hresetn)
      wr_mask |=>
        mask_q == ($past(hwdata[15:0]) & smt_pkg::VALID_MASK))
    else $error("mask register write not taken");
  a_fault_readback:
    assert property (@(posedge hclk) disable iff (!hresetn)
      addr_ph && !hwrite && haddr[smt_pkg::ADDR_W-1:0] == smt_pkg::FAULT_STATE_OFS |=>
        hrdata[15:0] == ~fault_n_q)
    else $error("fault state readback disagrees with fault flags");
  a_mon_en_read:
    assert property (@(posedge hclk) disable iff (!hresetn)
      addr_ph && !hwrite && haddr[smt_pkg::ADDR_W-1:0] == smt_pkg::MON_EN_OFS |=>
        hrdata[15:0] == mon_en_q)
    else $error("monitor enable readback wrong");
  a_upper_rdata_zero:
    assert property (@(posedge hclk) disable iff (!hresetn)
      hrdata[31:16] == 16'h0000)
    else $error("upper read data bits not zero");
  // Ready rises one edge after release, so the first edge is skipped
  a_bus_always_ok:
    assert property (@(posedge hclk) disable iff (!hresetn)
      $past(hresetn) |-> hreadyout && hresp == smt_pkg::HRESP_OKAY)
    else $error("bus slave stalled or answered with an error");
  a_unmapped_quiet:
    assert property (@(posedge hclk) disable iff (!hresetn)
      wr_pend_q && wr_sel == smt_pkg::SMT_SEL_NONE |=>
        $stable(selftest_q) && $stable(mon_en_q) && $stable(mask_q))
    else $error("write to an unmapped offset changed a register");

  c_sup_selftest:
    cover property (@(posedge hclk) disable iff (!hresetn) act_w[15] ##1 $fell(fault_n_q[15]));
  c_gnd_selftest:
    cover property (@(posedge hclk) disable iff (!hresetn) act_w[0] ##1 $fell(fault_n_q[0]));
  c_irq_raise:
    cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq));
  c_set_during_clear:
    cover property (@(posedge hclk) disable iff (!hresetn) wr_stat && (|(fault_rise & wdata)));
  c_read_after_write:
    cover property (@(posedge hclk) disable iff (!hresetn) wr_st && addr_ph && !hwrite);

endmodule : smt_selftest_cfg

// ---- sim/smt_selftest_cfg_tb.sv ----
`timescale 1ns/1ps
module smt_selftest_cfg_tb;
  // Short delays keep the run brief; every expectation derives from these
  localparam int unsigned SUP_D = 3;
  localparam int unsigned GND_D = 4;
  logic                 hclk;
  logic                 hresetn;
  logic                 hsel;
  logic [31:0]          haddr;
  logic [1:0]           htrans;
  logic                 hwrite;
  logic [2:0]           hsize;
  wire logic            hready;
  logic [31:0]          hwdata;
  logic [31:0]          hrdata;
  logic                 hreadyout;
  logic                 hresp;
  smt_pkg::smt_mon_type monitor_trip;
  smt_pkg::smt_mon_type monitor_en;
  smt_pkg::smt_mon_type fault_n;
  logic                 irq;
  logic [31:0]          rd_mid;
  logic                 rdy_mid;
  int                   error_cnt;
  int                   checks_done;

  smt_selftest_cfg #(.SUP_DELAY_CYC(SUP_D), .GND_DELAY_CYC(GND_D), .CNT_W(8)) smt_selftest_cfg_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .monitor_trip(monitor_trip), .monitor_en(monitor_en), .fault_n(fault_n), .irq(irq));

  assign hready = hreadyout;
  always #12.5 hclk = ~hclk;
  // Mid-cycle copies equal what the master samples at the next rising edge, free of races
  always @(negedge hclk) begin
    rd_mid  = hrdata;
    rdy_mid = hreadyout;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic ahb_xfer(input logic [7:0] a, input logic wr, input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= smt_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge hclk); while (rdy_mid !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (rdy_mid !== 1'b1);
    rd = rd_mid;
    chk({31'h0000_0000, hresp}, 32'h0000_0000);
  endtask : ahb_xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] unused;
    ahb_xfer(a, 1'b1, d, unused);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    ahb_xfer(a, 1'b0, 32'h0000_0000, d);
    chk(d, exp);
  endtask : rd_chk

  task automatic look(input logic [15:0] exp_fault, input logic exp_irq);
    @(negedge hclk);
    chk({16'h0000, fault_n}, {16'h0000, exp_fault});
    chk({31'h0000_0000, irq}, {31'h0000_0000, exp_irq});
    @(posedge hclk);
  endtask : look

  task automatic t_reset_values;
    look(16'hffff, 1'b0);
    chk({16'h0000, monitor_en}, 32'h0000_0000);
    rd_chk(smt_pkg::SELFTEST_OFS, 32'h0000_0000);
    rd_chk(smt_pkg::MON_EN_OFS, 32'h0000_0000);
    rd_chk(smt_pkg::IRQ_MASK_OFS, 32'h0000_0000);
  endtask : t_reset_values

  task automatic t_reserved_and_no_enable;
    wr(smt_pkg::SELFTEST_OFS, 32'hffff_ffff);
    rd_chk(smt_pkg::SELFTEST_OFS, 32'h0000_ff87);
    repeat (2 * GND_D) @(posedge hclk);
    look(16'hffff, 1'b0);
    // Enable arriving after the self-test bit still starts the test
    wr(smt_pkg::MON_EN_OFS, 32'h0000_0001);
    repeat (GND_D + 1) @(posedge hclk);
    look(16'hfffe, 1'b0);
    wr(smt_pkg::SELFTEST_OFS, 32'h0000_0000);
    wr(smt_pkg::MON_EN_OFS, 32'h0000_0000);
    wr(smt_pkg::IRQ_STATUS_OFS, 32'h0000_ffff);
  endtask : t_reserved_and_no_enable

  task automatic t_each_selftest;
    logic [15:0] m;
    int unsigned d;
    for (int i = 0; i < 16; i++) begin
      if (i < 3 || i > 6) begin
        m = 16'h0001 << i;
        d = (i <= 2) ? GND_D : SUP_D;
        wr(smt_pkg::MON_EN_OFS, {16'h0000, m});
        @(negedge hclk);
        chk({16'h0000, monitor_en}, {16'h0000, m});
        @(posedge hclk);
        wr(smt_pkg::SELFTEST_OFS, {16'h0000, m});
        repeat (d - 1) @(posedge hclk);
        look(16'hffff, 1'b0);
        look(~m, 1'b0);
        wr(smt_pkg::SELFTEST_OFS, 32'h0000_0000);
        look(~m, 1'b0);
        look(16'hffff, 1'b0);
        rd_chk(smt_pkg::IRQ_STATUS_OFS, {16'h0000, m});
        wr(smt_pkg::IRQ_STATUS_OFS, {16'h0000, m});
        rd_chk(smt_pkg::IRQ_STATUS_OFS, 32'h0000_0000);
      end
    end
    wr(smt_pkg::MON_EN_OFS, 32'h0000_0000);
  endtask : t_each_selftest

  task automatic t_interrupt;
    wr(smt_pkg::IRQ_MASK_OFS, 32'h0000_8000);
    wr(smt_pkg::MON_EN_OFS, 32'h0000_8001);
    monitor_trip <= 16'h0001;
    @(posedge hclk);
    look(16'hfffe, 1'b0);
    rd_chk(smt_pkg::IRQ_STATUS_OFS, 32'h0000_0001);
    monitor_trip <= 16'h8001;
    @(posedge hclk);
    look(16'h7ffe, 1'b1);
    rd_chk(smt_pkg::FAULT_STATE_OFS, 32'h0000_8001);
    // Held trip makes no new edge, so the clear sticks
    wr(smt_pkg::IRQ_STATUS_OFS, 32'h0000_8001);
    look(16'h7ffe, 1'b0);
    monitor_trip <= 16'h0000;
    @(posedge hclk);
    look(16'hffff, 1'b0);
    wr(smt_pkg::MON_EN_OFS, 32'h0000_0000);
    wr(smt_pkg::IRQ_MASK_OFS, 32'h0000_0000);
  endtask : t_interrupt

  task automatic t_unmapped;
    wr(8'h60, 32'h0000_ffff);
    rd_chk(8'h60, 32'h0000_0000);
    wr(smt_pkg::SELFTEST_OFS, 32'h0000_8001);
    rd_chk(smt_pkg::SELFTEST_OFS, 32'h0000_8001);
    wr(smt_pkg::SELFTEST_OFS, 32'h0000_0000);
  endtask : t_unmapped

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    monitor_trip = 16'h0000;
    error_cnt = 0;
    checks_done = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset_values();
    t_reserved_and_no_enable();
    t_each_selftest();
    t_interrupt();
    t_unmapped();
    complete_run();
  end

  // Full run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge hclk);
    error_cnt++;
    complete_run();
  end
endmodule : smt_selftest_cfg_tb
